// ===== rtl/wdt_pkg.sv
// Purpose: constants, register map and types of the windowed supervision timer
// Assumes: one sys_clk domain at 50 MHz, byte addresses on an 8-bit register port
// Notes: all offsets are word aligned, unused bits read as zero
//
// Operation
// - Missing reload before the count expires raises an internal chip reset, or interrupt in interrupt mode.
// - With windowing, a reload while count exceeds the window value is a violation.
// - A warning interrupt fires when the count equals the programmed warning value.
// - Enable is set-only; only hardware reset or a watchdog event clears it.
// - A wrong feed sequence causes chip reset, or interrupt in interrupt mode.
// - A sticky flag records that the watchdog caused the chip reset.
// - The counter is 24 bits, software-loaded, and runs behind a prescaler.
// - Time-out ranges 256x4 to 2^24x4 supervision clocks in steps of 4.
// - Software picks the internal RC or the dedicated supervision oscillator.
package wdt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 24;
  localparam int INT_W = 3;
  localparam int KEY_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TIMEOUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FEED = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_WARN = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_WINDOW = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CLKSEL = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_INT_CLEAR = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_CAUSE = 8'h28;

  // mode register fields
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_RSTSEL_BIT = 1;
  localparam logic MODE_RSTSEL_RESET = 1'b1;

  // single-bit register fields
  localparam int CLKSEL_BIT = 0;
  localparam int CAUSE_FLAG_BIT = 0;

  // interrupt status / clear / enable layout
  localparam int INT_TIMEOUT_BIT = 0;
  localparam int INT_WARN_BIT = 1;
  localparam int INT_FEEDERR_BIT = 2;

  // counter values
  localparam logic [CNT_W-1:0] TC_MIN = 24'h00_00ff;
  localparam logic [CNT_W-1:0] TC_RESET = 24'h00_00ff;
  localparam logic [CNT_W-1:0] WARN_RESET = 24'h00_0000;
  localparam logic [CNT_W-1:0] WIN_RESET = 24'hff_ffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;

  // feed keys
  localparam logic [KEY_W-1:0] FEED_KEY_FIRST = 8'haa;
  localparam logic [KEY_W-1:0] FEED_KEY_SECOND = 8'h55;

  // supervision clock selection and prescaler
  localparam logic CLKSEL_IRC = 1'b0;
  localparam int PRE_W = 2;
  localparam logic [PRE_W-1:0] PRE_LAST = 2'h3;

  typedef enum logic {
    FEED_IDLE = 1'b0,
    FEED_ARMED = 1'b1
  } feed_state_e;

endpackage

// ===== rtl/prescale_if.sv
// Purpose: carries source select, run and tick between timer core and prescaler
// Assumes: sys_clk domain on both ends
// Notes: tick is a one-cycle pulse every fourth supervision clock edge
`timescale 1ns/1ps
interface prescale_if;
  logic srcSel;
  logic run;
  logic tick;

  modport owner (output srcSel, output run, input tick);
  modport prescaler (input srcSel, input run, output tick);
endinterface

// ===== rtl/wdt_prescaler.sv
// Purpose: synchronises both supervision oscillators and divides the chosen one by 4
// Assumes: oscillators run well below a quarter of sys_clk
// Notes: a source switch may cost or add one edge, harmless for a watchdog
`timescale 1ns/1ps
module wdt_prescaler (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ircClk,
  input wire logic supOscClk,
  prescale_if.prescaler pif
);
  import wdt_pkg::*;

  logic [1:0] srcRaw;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic prev_r;
  logic selLevel;
  logic srcEdge;
  logic [PRE_W-1:0] div_r;
  logic tick_r;

  assign srcRaw = {supOscClk, ircClk};

  // two-stage synchronisers, one per oscillator
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gSync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= srcRaw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // source choice after the synchronisers only
  assign selLevel = (pif.srcSel == CLKSEL_IRC) ? sync2_r[0] : sync2_r[1];
  assign srcEdge = selLevel & ~prev_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= selLevel;
    end
  end

  // fixed divide by four; held clear while the timer is stopped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= pif.run && srcEdge && (div_r == PRE_LAST);
      if (!pif.run) begin
        div_r <= '0;
      end else if (srcEdge) begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  assign pif.tick = tick_r;
endmodule

// ===== rtl/windowed_supervision_timer.sv
// Purpose: windowed supervision timer with feed checking and warning interrupt
// Assumes: rstn is the chip hardware reset, never driven by chipResetOut
// Notes: fault response is chip reset or interrupt, chosen in the mode register
`timescale 1ns/1ps
module windowed_supervision_timer (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ircClk,
  input wire logic supOscClk,
  input wire logic [wdt_pkg::ADDR_W-1:0] regAddr,
  input wire logic [wdt_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [wdt_pkg::DATA_W-1:0] regRdData,
  output logic irq,
  output logic chipResetOut
);
  import wdt_pkg::*;

  // address match used by every decoder below
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  prescale_if pif ();

  logic enable_r;
  logic rstMode_r;
  logic clkSel_r;
  logic [CNT_W-1:0] tc_r;
  logic [CNT_W-1:0] warn_r;
  logic [CNT_W-1:0] win_r;
  logic [CNT_W-1:0] count_r;
  logic [INT_W-1:0] status_r;
  logic [INT_W-1:0] intEn_r;
  logic wdFlag_r;
  logic chipReset_r;
  logic [DATA_W-1:0] rdData_r;
  feed_state_e feedState_r;
  feed_state_e feedState_nxt;

  logic anyAccess;
  logic wrFeed;
  logic wrMode;
  logic enableSet;
  logic feedOk;
  logic seqErr;
  logic winErr;
  logic validFeed;
  logic timeoutEv;
  logic warnEv;
  logic fault;
  logic [INT_W-1:0] statusSet;
  logic [INT_W-1:0] statusClr;
  logic [CNT_W-1:0] tcWrite;

  logic wrTimeout;
  logic wrWarn;
  logic wrWindow;
  logic wrClkSel;
  logic wrIntClear;
  logic wrIntEnable;
  logic wrCause;
  logic winOpen;
  logic faultRst;
  logic [DATA_W-1:0] rdData_nxt;

  wdt_prescaler uPrescaler (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ircClk(ircClk),
    .supOscClk(supOscClk),
    .pif(pif)
  );

  // the prescaler only runs while the watchdog is armed
  assign pif.srcSel = clkSel_r;
  assign pif.run = enable_r;

  // bus decode
  assign anyAccess = regWrStrobe | regRdStrobe;
  assign wrFeed = regWrStrobe && hit(regAddr, OFF_FEED);
  assign wrMode = regWrStrobe && hit(regAddr, OFF_MODE);
  assign enableSet = wrMode && regWrData[MODE_EN_BIT] && !enable_r;

  // one write enable per register; a store never sees a strobe meant for a neighbour
  assign wrTimeout = regWrStrobe && hit(regAddr, OFF_TIMEOUT);
  assign wrWarn = regWrStrobe && hit(regAddr, OFF_WARN);
  assign wrWindow = regWrStrobe && hit(regAddr, OFF_WINDOW);
  assign wrClkSel = regWrStrobe && hit(regAddr, OFF_CLKSEL);
  assign wrIntClear = regWrStrobe && hit(regAddr, OFF_INT_CLEAR);
  assign wrIntEnable = regWrStrobe && hit(regAddr, OFF_INT_ENABLE);
  assign wrCause = regWrStrobe && hit(regAddr, OFF_CAUSE);

  // feed sequence tracker: first key arms, next access must be the second key
  always_comb begin
    feedState_nxt = feedState_r;
    unique case (feedState_r)
      FEED_IDLE: begin
        if (wrFeed && regWrData[KEY_W-1:0] == FEED_KEY_FIRST) begin
          feedState_nxt = FEED_ARMED;
        end
      end
      FEED_ARMED: begin
        // any access at all ends the armed state, good or bad
        if (anyAccess) begin
          feedState_nxt = FEED_IDLE;
        end
      end
    endcase
  end

  // held in a flop so a feed pair may straddle any number of idle cycles
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      feedState_r <= FEED_IDLE;
    end else begin
      feedState_r <= feedState_nxt;
    end
  end

  // feed checks; only count as faults while the watchdog is armed
  assign feedOk = (feedState_r == FEED_ARMED) && wrFeed && regWrData[KEY_W-1:0] == FEED_KEY_SECOND;
  assign seqErr = enable_r && (((feedState_r == FEED_ARMED) && anyAccess && !feedOk) ||
                  ((feedState_r == FEED_IDLE) && wrFeed &&
                   regWrData[KEY_W-1:0] != FEED_KEY_FIRST));
  // reload too early: count still above the window value; all ones keeps the window open
  assign winOpen = (count_r <= win_r);
  assign winErr = enable_r && feedOk && !winOpen;
  assign validFeed = feedOk && !winErr;

  // count events, sampled on prescaled ticks
  assign timeoutEv = enable_r && pif.tick && (count_r == CNT_ZERO);
  assign warnEv = enable_r && pif.tick && (count_r == warn_r);
  assign fault = timeoutEv | seqErr | winErr;
  assign faultRst = fault && (rstMode_r == MODE_RSTSEL_RESET);

  // enable is sticky: software may only set it, faults clear it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enable_r <= 1'b0;
    end else if (fault) begin
      enable_r <= 1'b0;
    end else if (enableSet) begin
      enable_r <= 1'b1;
    end
  end

  // response mode is frozen once armed so a runaway cannot soften it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstMode_r <= MODE_RSTSEL_RESET;
    end else if (wrMode && !enable_r) begin
      rstMode_r <= regWrData[MODE_RSTSEL_BIT];
    end
  end

  // clock source select, also frozen while armed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkSel_r <= CLKSEL_IRC;
    end else if (wrClkSel && !enable_r) begin
      clkSel_r <= regWrData[CLKSEL_BIT];
    end
  end

  // time-out constant; values under the minimum are raised to it
  assign tcWrite = (regWrData[CNT_W-1:0] < TC_MIN) ? TC_MIN : regWrData[CNT_W-1:0];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tc_r <= TC_RESET;
    end else if (wrTimeout) begin
      tc_r <= tcWrite;
    end
  end

  // warning compare value, free to change while armed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      warn_r <= WARN_RESET;
    end else if (wrWarn) begin
      warn_r <= regWrData[CNT_W-1:0];
    end
  end

  // window limit; all ones leaves the window open from the reload on
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      win_r <= WIN_RESET;
    end else if (wrWindow) begin
      win_r <= regWrData[CNT_W-1:0];
    end
  end

  // down counter: loads on arm or valid feed, one step per prescaled tick
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= TC_RESET;
    end else if (enableSet || validFeed) begin
      count_r <= tc_r;
    end else if (enable_r && pif.tick && count_r != CNT_ZERO) begin
      count_r <= count_r - CNT_ONE;
    end
  end

  // sticky interrupt status; a new event beats a simultaneous clear
  always_comb begin
    statusSet = '0;
    statusSet[INT_TIMEOUT_BIT] = timeoutEv;
    statusSet[INT_WARN_BIT] = warnEv;
    statusSet[INT_FEEDERR_BIT] = seqErr | winErr;
  end

  // clear is write-one, so untouched bits keep their events
  assign statusClr = wrIntClear ? regWrData[INT_W-1:0] : '0;

  // sticky store of the events
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~statusClr) | statusSet;
    end
  end

  // interrupt mask; masking hides a bit from irq but keeps it in status
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      intEn_r <= '0;
    end else if (wrIntEnable) begin
      intEn_r <= regWrData[INT_W-1:0];
    end
  end

  // level interrupt; in reset mode the chip reset usually wins anyway
  assign irq = |(status_r & intEn_r);

  // chip reset request, one cycle, only in reset mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chipReset_r <= 1'b0;
    end else begin
      chipReset_r <= faultRst;
    end
  end

  assign chipResetOut = chipReset_r;

  // reset cause flag survives the chip reset it requested, since rstn is separate
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wdFlag_r <= 1'b0;
    end else if (faultRst) begin
      wdFlag_r <= 1'b1;
    end else if (wrCause && regWrData[CAUSE_FLAG_BIT]) begin
      wdFlag_r <= 1'b0;
    end
  end

  // read mux; zero when no read is taken, so the port idles at zero
  always_comb begin
    rdData_nxt = '0;
    if (regRdStrobe) begin
      if (hit(regAddr, OFF_MODE)) begin
        rdData_nxt[MODE_EN_BIT] = enable_r;
        rdData_nxt[MODE_RSTSEL_BIT] = rstMode_r;
      end
      if (hit(regAddr, OFF_TIMEOUT)) begin
        rdData_nxt[CNT_W-1:0] = tc_r;
      end
      if (hit(regAddr, OFF_COUNT)) begin
        rdData_nxt[CNT_W-1:0] = count_r;
      end
      if (hit(regAddr, OFF_WARN)) begin
        rdData_nxt[CNT_W-1:0] = warn_r;
      end
      if (hit(regAddr, OFF_WINDOW)) begin
        rdData_nxt[CNT_W-1:0] = win_r;
      end
      if (hit(regAddr, OFF_CLKSEL)) begin
        rdData_nxt[CLKSEL_BIT] = clkSel_r;
      end
      if (hit(regAddr, OFF_INT_STATUS)) begin
        rdData_nxt[INT_W-1:0] = status_r;
      end
      if (hit(regAddr, OFF_INT_ENABLE)) begin
        rdData_nxt[INT_W-1:0] = intEn_r;
      end
      if (hit(regAddr, OFF_CAUSE)) begin
        rdData_nxt[CAUSE_FLAG_BIT] = wdFlag_r;
      end
    end
  end

  // registered copy stands exactly one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdData_r <= '0;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;
endmodule

// ===== bench/wdt_asserts.sv
// Purpose: port-level checks of the windowed supervision timer
// Assumes: register port of one-cycle strobes, read data one cycle later
// Notes: interrupt enable is shadowed from writes, since it is not visible at the ports
`timescale 1ns/1ps
module wdt_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ircClk,
  input wire logic supOscClk,
  input wire logic [wdt_pkg::ADDR_W-1:0] regAddr,
  input wire logic [wdt_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [wdt_pkg::DATA_W-1:0] regRdData,
  input wire logic irq,
  input wire logic chipResetOut
);
  import wdt_pkg::*;
  logic [INT_W-1:0] ieShadow_r;
  // copy of the interrupt enable register, taken from the write port
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ieShadow_r <= '0;
    end else if (regWrStrobe && regAddr == OFF_INT_ENABLE) begin
      ieShadow_r <= regWrData[INT_W-1:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // steps of the enable and cause sequences
  sequence enWrS;
    regWrStrobe && regAddr == OFF_MODE && regWrData[MODE_EN_BIT];
  endsequence
  sequence offWrS;
    regWrStrobe && regAddr == OFF_MODE && !regWrData[MODE_EN_BIT];
  endsequence
  sequence modeRdS;
    regRdStrobe && regAddr == OFF_MODE;
  endsequence
  sequence causeRdS;
    regRdStrobe && regAddr == OFF_CAUSE;
  endsequence
  reset_pulse_a: assert property (chipResetOut |=> !chipResetOut)
    else $error("chip reset longer than one cycle");
  enable_sticky_a: assert property (enWrS ##2 offWrS ##2 modeRdS |=> regRdData[MODE_EN_BIT])
    else $error("enable cleared by software");
  cause_flag_a: assert property (chipResetOut ##1 causeRdS |=> regRdData[0])
    else $error("cause flag missing after chip reset");
  count_width_a: assert property ((regRdStrobe && regAddr == OFF_COUNT) |=> regRdData[DATA_W-1:CNT_W] == '0)
    else $error("count wider than 24 bits");
  timeout_floor_a: assert property ((regRdStrobe && regAddr == OFF_TIMEOUT) |=>
    regRdData[CNT_W-1:0] >= TC_MIN && regRdData[DATA_W-1:CNT_W] == '0)
    else $error("time-out value out of range");
  irq_level_a: assert property ((regRdStrobe && regAddr == OFF_INT_STATUS) |=>
    $past(irq) == |(regRdData[INT_W-1:0] & $past(ieShadow_r)))
    else $error("irq does not match enabled status");
  irq_hold_a: assert property ($fell(irq) |-> $past(regWrStrobe))
    else $error("irq dropped without a write");
  read_idle_a: assert property ((regRdData != '0) |-> $past(regRdStrobe))
    else $error("read data outside the read cycle");
endmodule

bind windowed_supervision_timer wdt_asserts chk (.sys_clk(sys_clk), .rstn(rstn), .ircClk(ircClk),
  .supOscClk(supOscClk), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
  .regRdStrobe(regRdStrobe), .regRdData(regRdData), .irq(irq), .chipResetOut(chipResetOut));

// ===== bench/test_windowed_supervision_timer.sv
// Purpose: self-checking bench of the windowed supervision timer
// Assumes: rc osc 200 ns, supervision osc 260 ns, one tick per four edges
// Notes: a tick is 40 sys_clk on the rc osc, so one time-out costs about 10k cycles
`timescale 1ns/1ps
module test_windowed_supervision_timer;
  import wdt_pkg::*;
  localparam logic [DATA_W-1:0] YES = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] RA [11] = '{OFF_MODE, OFF_TIMEOUT, OFF_WARN, OFF_WINDOW, OFF_CLKSEL,
    OFF_COUNT, OFF_INT_STATUS, OFF_INT_ENABLE, OFF_CAUSE, OFF_FEED, 8'h2c};
  localparam logic [CNT_W-1:0] RV [11] = '{24'h00_0002, TC_RESET, WARN_RESET, WIN_RESET, 24'h00_0000,
    TC_RESET, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic rcOsc = 1'b0;
  logic supOscClk = 1'b0;
  logic rcRun = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic [DATA_W-1:0] rdv;
  logic irq;
  logic chipResetOut;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  // clocks; the rc osc stands still when stopped, so a count that moves proves the switch
  always #10 sys_clk = ~sys_clk;
  always #100 if (rcRun) rcOsc = ~rcOsc;
  always #130 supOscClk = ~supOscClk;
  windowed_supervision_timer DUT (.sys_clk(sys_clk), .rstn(rstn), .ircClk(rcOsc), .supOscClk(supOscClk),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regRdData), .irq(irq), .chipResetOut(chipResetOut));
  // bus helpers; every access leaves one idle cycle so no strobe is driven twice per step
  task chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge sys_clk);
    regWrStrobe <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge sys_clk);
    regRdStrobe <= 1'b0;
    #1 rdv = regRdData;
  endtask
  task rdc(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd(a);
    chk(what, e, rdv);
  endtask
  task feed;
    wr(OFF_FEED, 32'(FEED_KEY_FIRST));
    wr(OFF_FEED, 32'(FEED_KEY_SECOND));
  endtask
  // bounded wait for irq or the chip reset pulse, n keeps the cycles spent
  task await_pin(input string what, input logic useIrq, input int lim);
    n = 0;
    #1;
    while ((useIrq ? irq : chipResetOut) !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(what, YES, 32'(useIrq ? irq : chipResetOut));
  endtask
  task t_reset;
    for (int i = 0; i < 11; i++) begin
      rdc("reset value", RA[i], 32'(RV[i]));
    end
    $display("t_reset done");
  endtask
  task t_reg;
    wr(OFF_TIMEOUT, 32'h0000_0010);
    rdc("timeout floor", OFF_TIMEOUT, 32'(TC_MIN));
    wr(OFF_TIMEOUT, 32'hffff_ffff);
    rdc("timeout ceiling", OFF_TIMEOUT, 32'h00ff_ffff);
    wr(OFF_TIMEOUT, 32'h0000_0100);
    rdc("timeout step", OFF_TIMEOUT, 32'h0000_0100);
    wr(OFF_COUNT, 32'h0000_0010);
    wr(8'h2c, 32'hffff_ffff);
    rdc("count read only", OFF_COUNT, 32'(TC_RESET));
    rdc("unmapped", 8'h2c, 32'h0000_0000);
    wr(OFF_TIMEOUT, 32'(TC_MIN));
    $display("t_reg done");
  endtask
  task t_timeout;
    wr(OFF_WARN, 32'h0000_0080);
    wr(OFF_INT_ENABLE, 32'h0000_0002);
    wr(OFF_MODE, 32'h0000_0003);
    wr(OFF_MODE, 32'h0000_0000);
    rdc("enable sticky", OFF_MODE, 32'h0000_0003);
    wr(OFF_CLKSEL, YES);
    rdc("clock select locked", OFF_CLKSEL, 32'h0000_0000);
    await_pin("warn irq", 1'b1, 6000);
    rdc("count at warning", OFF_COUNT, 32'h0000_007f);
    rdc("warn status", OFF_INT_STATUS, 32'h0000_0002);
    wr(OFF_INT_CLEAR, 32'h0000_0002);
    rdc("warn cleared", OFF_INT_STATUS, 32'h0000_0000);
    chk("irq low", 32'h0000_0000, 32'(irq));
    feed;
    rd(OFF_COUNT);
    chk("count reloaded", YES, 32'(rdv[CNT_W-1:0] > 24'h00_00fd));
    await_pin("time-out reset", 1'b0, 12000);
    chk("time-out period", YES, 32'(n > 10150 && n < 10260));
    rdc("cause flag", OFF_CAUSE, YES);
    rdc("enable cleared", OFF_MODE, 32'h0000_0002);
    rdc("time-out status", OFF_INT_STATUS, 32'h0000_0003);
    wr(OFF_INT_CLEAR, 32'h0000_0007);
    wr(OFF_CAUSE, YES);
    rdc("cause cleared", OFF_CAUSE, 32'h0000_0000);
    $display("t_timeout done");
  endtask
  task t_window;
    wr(OFF_WARN, 32'h0000_0000);
    wr(OFF_MODE, 32'h0000_0000);
    wr(OFF_INT_ENABLE, 32'h0000_0007);
    wr(OFF_WINDOW, 32'h0000_0080);
    wr(OFF_MODE, YES);
    feed;
    await_pin("early feed irq", 1'b1, 4);
    rdc("early feed disables", OFF_MODE, 32'h0000_0000);
    rdc("no reset in irq mode", OFF_CAUSE, 32'h0000_0000);
    wr(OFF_INT_CLEAR, 32'h0000_0007);
    wr(OFF_MODE, YES);
    n = 0;
    rd(OFF_COUNT);
    while (rdv[CNT_W-1:0] > 24'h00_0070 && n < 4000) begin
      rd(OFF_COUNT);
      n++;
    end
    chk("count inside window", YES, 32'(rdv[CNT_W-1:0] <= 24'h00_0070));
    feed;
    rdc("late feed accepted", OFF_INT_STATUS, 32'h0000_0000);
    wr(OFF_FEED, 32'h0000_0012);
    await_pin("bad key irq", 1'b1, 4);
    rdc("bad key status", OFF_INT_STATUS, 32'h0000_0004);
    wr(OFF_INT_CLEAR, 32'h0000_0007);
    wr(OFF_WINDOW, 32'(WIN_RESET));
    $display("t_window done");
  endtask
  task t_clksel;
    wr(OFF_MODE, 32'h0000_0002);
    wr(OFF_CLKSEL, YES);
    rdc("clock select", OFF_CLKSEL, YES);
    rcRun = 1'b0;
    wr(OFF_MODE, 32'h0000_0003);
    n = 0;
    rd(OFF_COUNT);
    while (rdv[CNT_W-1:0] > 24'h00_00fc && n < 300) begin
      rd(OFF_COUNT);
      n++;
    end
    chk("count on supervision osc", YES, 32'(rdv[CNT_W-1:0] < 24'h00_00fd));
    wr(OFF_FEED, 32'(FEED_KEY_FIRST));
    rd(OFF_WARN);
    await_pin("broken feed reset", 1'b0, 4);
    rdc("feed fault cause", OFF_CAUSE, YES);
    wr(OFF_CAUSE, YES);
    rcRun = 1'b1;
    $display("t_clksel done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence after a six-cycle reset
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_reg;
    t_timeout;
    t_window;
    t_clksel;
    finish_test;
  end
  // hang guard: the tests need about 21k cycles
  initial begin
    #1_000_000;
    bad_count++;
    $display("FAIL watchdog expected done seen hang");
    finish_test;
  end
endmodule
